/* File: design/ipe_pkg.sv */
// Operation
// R1: Priority register bit 7 unused, always reads one, writes to it ignored.
// R2: Priority register at address 0xB8, single bits settable and clearable.
// R3: Priority bit 6 sets SPI port level, one is high.
// R4: Priority bit 5 sets timer 2 level, one is high.
// R5: Priority bit 4 sets UART level, one is high.
// R6: Priority bit 3 sets timer 1 level, one is high.
// R7: Priority bit 2 sets external interrupt 1 level, one is high.
// R8: Priority bit 1 sets timer 0 level, one is high.
// R9: Priority bit 0 sets external interrupt 0 level, one is high.
// R10: Mask bit 7 passes timer 3 on low or high overflow flag.
// R11: Software writes zero to reserved mask bit 6.
// R12: Mask bit 5 passes comparator on rise or fall flag.
// R13: Mask bit 4 passes counter array requests.
// R14: Mask bit 3 passes ADC conversion-done request.
// R15: Mask bit 2 passes ADC window-compare request.
// R16: Mask bit 1 passes port-match requests.
// R17: Mask bit 0 passes SMBus port requests.
// R18: Global gate zero blocks all sources; one follows individual masks.
// R19: Writable bits of both registers clear to zero on reset.
package ipe_pkg;
   localparam logic [7:0] IPE_LEVEL_ADDR = 8'hb8;
   localparam logic [7:0] IPE_MASK_ADDR = 8'he6;
   localparam logic [7:0] IPE_LEVEL_RST = 8'h80;
   localparam logic [7:0] IPE_MASK_RST = 8'h00;
   localparam logic [7:0] IPE_LEVEL_WMASK = 8'h7f;
   localparam int IPE_UNUSED_BIT = 7;
   localparam int IPE_SPI_BIT = 6;
   localparam int IPE_T2_BIT = 5;
   localparam int IPE_UART_BIT = 4;
   localparam int IPE_T1_BIT = 3;
   localparam int IPE_X1_BIT = 2;
   localparam int IPE_T0_BIT = 1;
   localparam int IPE_X0_BIT = 0;
   localparam int IPE_T3_BIT = 7;
   localparam int IPE_RSVD_BIT = 6;
   localparam int IPE_CMP_BIT = 5;
   localparam int IPE_PCA_BIT = 4;
   localparam int IPE_ADC_BIT = 3;
   localparam int IPE_WIN_BIT = 2;
   localparam int IPE_MAT_BIT = 1;
   localparam int IPE_SMB_BIT = 0;
   localparam int IPE_NUM_EXT = 7;
endpackage

/* File: design/ipe_gate_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Bundle between register top and request gate
interface ipe_gate_if;
   logic [7:0] mask;
   logic global_en;
   logic [6:0] raw;
   logic [6:0] gated;
   modport regs (output mask, output global_en, output raw, input gated);
   modport gate (input mask, input global_en, input raw, output gated);
endinterface
`default_nettype wire

/* File: design/ipe_req_gate.sv */
`timescale 1ns/1ns
`default_nettype none
// Combinational request gating of the extended sources
module ipe_req_gate
   import ipe_pkg::*;
(
   ipe_gate_if.gate g
);
   // ----------------------------------------
   // Mask and global gate
   // ----------------------------------------
   always_comb begin
      g.gated[6] = g.global_en & g.mask[IPE_T3_BIT] & g.raw[6]; // R10 R18
      g.gated[5] = g.global_en & g.mask[IPE_CMP_BIT] & g.raw[5]; // R12
      g.gated[4] = g.global_en & g.mask[IPE_PCA_BIT] & g.raw[4]; // R13
      g.gated[3] = g.global_en & g.mask[IPE_ADC_BIT] & g.raw[3]; // R14
      g.gated[2] = g.global_en & g.mask[IPE_WIN_BIT] & g.raw[2]; // R15
      g.gated[1] = g.global_en & g.mask[IPE_MAT_BIT] & g.raw[1]; // R16
      g.gated[0] = g.global_en & g.mask[IPE_SMB_BIT] & g.raw[0]; // R17
   end
endmodule // ipe_req_gate
`default_nettype wire

/* File: design/ipe_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Priority and extended mask registers with request gating
module ipe_top
   import ipe_pkg::*;
(
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic ce_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic sfr_bit_wr_in,
   input wire logic [2:0] sfr_bit_sel_in,
   input wire logic sfr_bit_val_in,
   input wire logic global_irq_gate_in,
   input wire logic timer_three_low_overflow_in,
   input wire logic timer_three_high_overflow_in,
   input wire logic comparator_rise_flag_in,
   input wire logic comparator_fall_flag_in,
   input wire logic counter_array_req_in,
   input wire logic conversion_done_flag_in,
   input wire logic window_compare_flag_in,
   input wire logic port_match_req_in,
   input wire logic smbus_port_req_in,
   output logic [7:0] sfr_rdata_out,
   output logic [7:0] irq_level_out,
   output logic [6:0] ext_req_out
);
   logic [7:0] irq_level_select_reg;
   logic [7:0] extended_irq_mask_reg;
   logic [7:0] level_next;
   logic lvl_hit;
   logic msk_hit;
   ipe_gate_if gif();

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   assign lvl_hit = (sfr_addr_in == IPE_LEVEL_ADDR); // R2
   assign msk_hit = (sfr_addr_in == IPE_MASK_ADDR);

   // Byte write or single-bit read-modify of the priority register
   always_comb begin
      level_next = irq_level_select_reg;
      if (sfr_wr_in) begin
         level_next = sfr_wdata_in;
      end else if (sfr_bit_wr_in) begin
         level_next[sfr_bit_sel_in] = sfr_bit_val_in; // R2
      end
      level_next = (level_next & IPE_LEVEL_WMASK) | IPE_LEVEL_RST; // R1
   end

   // ----------------------------------------
   // Priority register
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         irq_level_select_reg <= IPE_LEVEL_RST; // R19
      end else if (ce_in && lvl_hit && (sfr_wr_in || sfr_bit_wr_in)) begin
         irq_level_select_reg <= level_next; // R3 R4 R5 R6 R7 R8 R9
      end
   end

   // Extended mask register, byte writes; reserved bit stored as written
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         extended_irq_mask_reg <= IPE_MASK_RST; // R19
      end else if (ce_in && msk_hit && sfr_wr_in) begin
         extended_irq_mask_reg <= sfr_wdata_in; // R11
      end
   end

   // ----------------------------------------
   // Request gating
   // ----------------------------------------
   assign gif.mask = extended_irq_mask_reg;
   assign gif.global_en = global_irq_gate_in;
   assign gif.raw = {timer_three_low_overflow_in | timer_three_high_overflow_in, // R10
                     comparator_rise_flag_in | comparator_fall_flag_in, // R12
                     counter_array_req_in, conversion_done_flag_in, window_compare_flag_in,
                     port_match_req_in, smbus_port_req_in};
   ipe_req_gate u_gate (.g(gif));

   // Registered outputs
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         ext_req_out <= 7'h00;
         irq_level_out <= IPE_LEVEL_RST;
         sfr_rdata_out <= 8'h00;
      end else if (ce_in) begin
         ext_req_out <= gif.gated; // R18
         irq_level_out <= irq_level_select_reg;
         if (lvl_hit) begin
            sfr_rdata_out <= irq_level_select_reg;
         end else if (msk_hit) begin
            sfr_rdata_out <= extended_irq_mask_reg;
         end else begin
            sfr_rdata_out <= 8'h00;
         end
      end
   end

   // ----------------------------------------
   // Assertions: priority register
   // ----------------------------------------
   // Bit 7 is forced high and a bit write cannot clear it
   a_unused_reads_one: assert property ( // R1
      @(posedge clk_in) disable iff (srst_in)
      irq_level_select_reg[IPE_UNUSED_BIT])
      else $error("unused bit not one");
   a_bit_seven_kept: assert property ( // R1
      @(posedge clk_in) disable iff (srst_in)
      ce_in && lvl_hit && sfr_bit_wr_in && !sfr_wr_in && sfr_bit_sel_in == 3'h7
      |=> irq_level_select_reg == $past(irq_level_select_reg))
      else $error("bit 7 write not ignored");

   // Single-bit access changes the chosen bit only
   a_bit_write_lvl: assert property ( // R2
      @(posedge clk_in) disable iff (srst_in)
      ce_in && lvl_hit && sfr_bit_wr_in && !sfr_wr_in && sfr_bit_sel_in != 3'h7
      |=> irq_level_select_reg[$past(sfr_bit_sel_in)] == $past(sfr_bit_val_in))
      else $error("bit write lost");
   a_bit_write_others: assert property ( // R2
      @(posedge clk_in) disable iff (srst_in)
      ce_in && lvl_hit && sfr_bit_wr_in && !sfr_wr_in
      |=> ((irq_level_select_reg ^ $past(irq_level_select_reg)) & ~(8'h01 << $past(sfr_bit_sel_in))) == 8'h00)
      else $error("bit write touched other bits");

   // Byte write lands in bits 6 to 0 and wins over a bit write
   a_byte_write_lvl: assert property ( // R3
      @(posedge clk_in) disable iff (srst_in)
      ce_in && lvl_hit && sfr_wr_in
      |=> irq_level_select_reg[6:0] == $past(sfr_wdata_in[6:0]))
      else $error("level write lost");
   a_byte_wins: assert property ( // R2
      @(posedge clk_in) disable iff (srst_in)
      ce_in && lvl_hit && sfr_wr_in && sfr_bit_wr_in
      |=> irq_level_select_reg == ($past(sfr_wdata_in) | IPE_LEVEL_RST))
      else $error("byte write did not win");

   // ----------------------------------------
   // Assertions: priority level outputs
   // ----------------------------------------
   // Each level output bit shows its register bit one edge later
   a_spi_port_level: assert property ( // R3
      @(posedge clk_in) disable iff (srst_in)
      ce_in |=> irq_level_out[IPE_SPI_BIT] == $past(irq_level_select_reg[IPE_SPI_BIT]))
      else $error("spi port level wrong");
   a_timer_two_level: assert property ( // R4
      @(posedge clk_in) disable iff (srst_in)
      ce_in |=> irq_level_out[IPE_T2_BIT] == $past(irq_level_select_reg[IPE_T2_BIT]))
      else $error("timer 2 level wrong");
   a_uart_level: assert property ( // R5
      @(posedge clk_in) disable iff (srst_in)
      ce_in |=> irq_level_out[IPE_UART_BIT] == $past(irq_level_select_reg[IPE_UART_BIT]))
      else $error("uart level wrong");
   a_timer_one_level: assert property ( // R6
      @(posedge clk_in) disable iff (srst_in)
      ce_in |=> irq_level_out[IPE_T1_BIT] == $past(irq_level_select_reg[IPE_T1_BIT]))
      else $error("timer 1 level wrong");
   a_ext_one_level: assert property ( // R7
      @(posedge clk_in) disable iff (srst_in)
      ce_in |=> irq_level_out[IPE_X1_BIT] == $past(irq_level_select_reg[IPE_X1_BIT]))
      else $error("external 1 level wrong");
   a_timer_zero_level: assert property ( // R8
      @(posedge clk_in) disable iff (srst_in)
      ce_in |=> irq_level_out[IPE_T0_BIT] == $past(irq_level_select_reg[IPE_T0_BIT]))
      else $error("timer 0 level wrong");
   a_ext_zero_level: assert property ( // R9
      @(posedge clk_in) disable iff (srst_in)
      ce_in |=> irq_level_out[IPE_X0_BIT] == $past(irq_level_select_reg[IPE_X0_BIT]))
      else $error("external 0 level wrong");

   // ----------------------------------------
   // Assertions: clock enable and decode
   // ----------------------------------------
   // A low clock enable holds every register and output
   a_state_freeze: assert property (
      @(posedge clk_in) disable iff (srst_in)
      !ce_in |=> $stable(irq_level_select_reg) && $stable(extended_irq_mask_reg))
      else $error("state moved while frozen");
   a_output_freeze: assert property (
      @(posedge clk_in) disable iff (srst_in)
      !ce_in |=> $stable(sfr_rdata_out) && $stable(irq_level_out) && $stable(ext_req_out))
      else $error("output moved while frozen");

   // Unmapped writes and bit writes to the mask change nothing
   a_unmapped_ignored: assert property (
      @(posedge clk_in) disable iff (srst_in)
      ce_in && !lvl_hit && !msk_hit
      |=> $stable(irq_level_select_reg) && $stable(extended_irq_mask_reg))
      else $error("unmapped access changed a register");
   a_mask_bit_ignored: assert property ( // R2
      @(posedge clk_in) disable iff (srst_in)
      ce_in && msk_hit && sfr_bit_wr_in && !sfr_wr_in |=> $stable(extended_irq_mask_reg))
      else $error("bit write reached mask");

   // Read data shows the addressed register one edge later
   a_read_level: assert property ( // R2
      @(posedge clk_in) disable iff (srst_in)
      ce_in && lvl_hit |=> sfr_rdata_out == $past(irq_level_select_reg))
      else $error("level read wrong");
   a_read_mask: assert property (
      @(posedge clk_in) disable iff (srst_in)
      ce_in && msk_hit |=> sfr_rdata_out == $past(extended_irq_mask_reg))
      else $error("mask read wrong");
   a_read_other: assert property (
      @(posedge clk_in) disable iff (srst_in)
      ce_in && !lvl_hit && !msk_hit |=> sfr_rdata_out == 8'h00)
      else $error("unmapped read not zero");

   // ----------------------------------------
   // Assertions: extended mask and requests
   // ----------------------------------------
   // Mask takes byte writes whole, reserved bit included
   a_mask_write: assert property ( // R11
      @(posedge clk_in) disable iff (srst_in)
      ce_in && msk_hit && sfr_wr_in |=> extended_irq_mask_reg == $past(sfr_wdata_in))
      else $error("mask write lost");

   // Global gate low silences every request
   a_gate_blocks: assert property ( // R18
      @(posedge clk_in) disable iff (srst_in)
      ce_in && !global_irq_gate_in |=> ext_req_out == 7'h00)
      else $error("gate leak");

   // Timer 3 passes on either overflow flag
   a_timer_three: assert property ( // R10
      @(posedge clk_in) disable iff (srst_in)
      ce_in && global_irq_gate_in && extended_irq_mask_reg[IPE_T3_BIT] && timer_three_high_overflow_in
      |=> ext_req_out[6])
      else $error("timer 3 not passed");
   a_timer_three_low: assert property ( // R10
      @(posedge clk_in) disable iff (srst_in)
      ce_in && global_irq_gate_in && extended_irq_mask_reg[IPE_T3_BIT] && timer_three_low_overflow_in
      |=> ext_req_out[6])
      else $error("timer 3 low not passed");
   a_timer_three_block: assert property ( // R10
      @(posedge clk_in) disable iff (srst_in)
      ce_in && !extended_irq_mask_reg[IPE_T3_BIT] |=> !ext_req_out[6])
      else $error("timer 3 leak");

   // Comparator passes on either edge flag
   a_comparator_pass: assert property ( // R12
      @(posedge clk_in) disable iff (srst_in)
      ce_in && global_irq_gate_in && extended_irq_mask_reg[IPE_CMP_BIT] && comparator_fall_flag_in
      |=> ext_req_out[5])
      else $error("comparator not passed");
   a_comparator_rise: assert property ( // R12
      @(posedge clk_in) disable iff (srst_in)
      ce_in && global_irq_gate_in && extended_irq_mask_reg[IPE_CMP_BIT] && comparator_rise_flag_in
      |=> ext_req_out[5])
      else $error("comparator rise not passed");
   a_comparator_block: assert property ( // R12
      @(posedge clk_in) disable iff (srst_in)
      ce_in && !extended_irq_mask_reg[IPE_CMP_BIT] |=> !ext_req_out[5])
      else $error("comparator leak");

   // Single-flag sources pass only with their mask bit set
   a_counter_pass: assert property ( // R13
      @(posedge clk_in) disable iff (srst_in)
      ce_in && global_irq_gate_in && extended_irq_mask_reg[IPE_PCA_BIT] && counter_array_req_in
      |=> ext_req_out[4])
      else $error("counter array not passed");
   a_counter_block: assert property ( // R13
      @(posedge clk_in) disable iff (srst_in)
      ce_in && !extended_irq_mask_reg[IPE_PCA_BIT] |=> !ext_req_out[4])
      else $error("counter array leak");
   a_conv_done_pass: assert property ( // R14
      @(posedge clk_in) disable iff (srst_in)
      ce_in && global_irq_gate_in && extended_irq_mask_reg[IPE_ADC_BIT] && conversion_done_flag_in
      |=> ext_req_out[3])
      else $error("conversion done not passed");
   a_conv_done_block: assert property ( // R14
      @(posedge clk_in) disable iff (srst_in)
      ce_in && !extended_irq_mask_reg[IPE_ADC_BIT] |=> !ext_req_out[3])
      else $error("conversion done leak");
   a_window_pass: assert property ( // R15
      @(posedge clk_in) disable iff (srst_in)
      ce_in && global_irq_gate_in && extended_irq_mask_reg[IPE_WIN_BIT] && window_compare_flag_in
      |=> ext_req_out[2])
      else $error("window compare not passed");
   a_window_block: assert property ( // R15
      @(posedge clk_in) disable iff (srst_in)
      ce_in && !extended_irq_mask_reg[IPE_WIN_BIT] |=> !ext_req_out[2])
      else $error("window compare leak");
   a_port_match_pass: assert property ( // R16
      @(posedge clk_in) disable iff (srst_in)
      ce_in && global_irq_gate_in && extended_irq_mask_reg[IPE_MAT_BIT] && port_match_req_in
      |=> ext_req_out[1])
      else $error("port match not passed");
   a_port_match_block: assert property ( // R16
      @(posedge clk_in) disable iff (srst_in)
      ce_in && !extended_irq_mask_reg[IPE_MAT_BIT] |=> !ext_req_out[1])
      else $error("port match leak");
   a_smbus_pass: assert property ( // R17
      @(posedge clk_in) disable iff (srst_in)
      ce_in && global_irq_gate_in && extended_irq_mask_reg[IPE_SMB_BIT] && smbus_port_req_in
      |=> ext_req_out[0])
      else $error("smbus not passed");
   a_masked_smb: assert property ( // R17
      @(posedge clk_in) disable iff (srst_in)
      ce_in && !extended_irq_mask_reg[IPE_SMB_BIT] |=> !ext_req_out[0])
      else $error("smbus leak");

   // ----------------------------------------
   // Assertions: reset
   // ----------------------------------------
   a_reset_vals: assert property ( // R19
      @(posedge clk_in)
      srst_in |=> irq_level_select_reg == IPE_LEVEL_RST && extended_irq_mask_reg == IPE_MASK_RST)
      else $error("reset value wrong");
   a_reset_outputs: assert property ( // R19
      @(posedge clk_in)
      srst_in |=> ext_req_out == 7'h00 && irq_level_out == IPE_LEVEL_RST && sfr_rdata_out == 8'h00)
      else $error("reset output wrong");

   // ----------------------------------------
   // Covers of the main scenarios
   // ----------------------------------------
   c_lvl_bit: cover property (@(posedge clk_in) ce_in && lvl_hit && sfr_bit_wr_in);
   c_mask_wr: cover property (@(posedge clk_in) ce_in && msk_hit && sfr_wr_in);
   c_req_out: cover property (@(posedge clk_in) ext_req_out != 7'h00);
   c_byte_and_bit: cover property (@(posedge clk_in) ce_in && lvl_hit && sfr_wr_in && sfr_bit_wr_in);
   c_frozen_write: cover property (@(posedge clk_in) !ce_in && (sfr_wr_in || sfr_bit_wr_in));
endmodule // ipe_top
`default_nettype wire

/* File: dv/ipe_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Core side of the SFR bus
module ipe_core_model
   import ipe_pkg::*;
(
   input wire logic clk_in,
   output logic [7:0] addr_out,
   output logic wr_out,
   output logic [7:0] wdata_out,
   output logic bit_wr_out,
   output logic [2:0] sel_out,
   output logic val_out
);
   initial begin
      {addr_out, wr_out, wdata_out, bit_wr_out, sel_out, val_out} = '0;
   end
   // One access held over one edge, then strobes drop and data flips for one idle edge,
   // so that no signal is driven twice in one time step between two accesses
   task automatic put(input logic [7:0] a, input logic w, input logic [7:0] d, input logic b,
                      input logic [2:0] s, input logic v);
      if (a == IPE_MASK_ADDR) d[6] = 1'b0;
      {addr_out, wr_out, wdata_out, bit_wr_out, sel_out, val_out} = {a, w, d, b, s, v};
      @(posedge clk_in);
      #1;
      {wr_out, bit_wr_out, wdata_out} = {1'b0, 1'b0, ~d};
      @(posedge clk_in);
      #1;
   endtask
endmodule // ipe_core_model
`default_nettype wire

/* File: dv/tb_irq_priority_and_ext_enable.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_irq_priority_and_ext_enable;
   import ipe_pkg::*;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic ce_in = 1'b1;
   logic gate = 1'b0;
   logic [8:0] flags = '0;
   logic [7:0] addr, wdata, rdata, level, lvl, msk, a;
   logic wr, bwr, bval;
   logic [2:0] bsel;
   logic [6:0] req;
   logic [31:0] seed = 32'd75;
   logic [31:0] r;
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;
   ipe_core_model ipe_core_model_i (.clk_in(clk_in), .addr_out(addr), .wr_out(wr), .wdata_out(wdata),
      .bit_wr_out(bwr), .sel_out(bsel), .val_out(bval));
   ipe_top ipe_top_i (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
      .sfr_wdata_in(wdata), .sfr_bit_wr_in(bwr), .sfr_bit_sel_in(bsel), .sfr_bit_val_in(bval),
      .global_irq_gate_in(gate), .timer_three_low_overflow_in(flags[0]), .timer_three_high_overflow_in(flags[1]),
      .comparator_rise_flag_in(flags[2]), .comparator_fall_flag_in(flags[3]), .counter_array_req_in(flags[4]),
      .conversion_done_flag_in(flags[5]), .window_compare_flag_in(flags[6]), .port_match_req_in(flags[7]),
      .smbus_port_req_in(flags[8]), .sfr_rdata_out(rdata), .irq_level_out(level), .ext_req_out(req));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [6:0] exp_req();
      return {msk[7] & (flags[0] | flags[1]), msk[5] & (flags[2] | flags[3]), msk[4] & flags[4],
              msk[3] & flags[5], msk[2] & flags[6], msk[1] & flags[7], msk[0] & flags[8]} & {7{gate}};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] ra, input logic [7:0] exp);
      ipe_core_model_i.put(ra, 1'b0, 8'h00, 1'b0, 3'h0, 1'b0);
      chk(rdata, exp);
   endtask
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Clock and hang guard
   initial forever #20 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 2000) begin
         err_total++;
         report_and_stop();
      end
   end
   // Main sequence
   initial begin
      lvl = 8'h80;
      msk = 8'h00;
      repeat (5) @(posedge clk_in);
      #1 srst_in = 1'b0;
      chk(level, lvl);
      rd_chk(IPE_LEVEL_ADDR, 8'h80);
      rd_chk(IPE_MASK_ADDR, 8'h00);
      // Random byte writes, an unmapped place among them
      for (int i = 0; i < 24; i++) begin
         r = xs();
         a = (r[9:8] == 2'd0) ? 8'h55 : r[8] ? IPE_LEVEL_ADDR : IPE_MASK_ADDR;
         ipe_core_model_i.put(a, 1'b1, r[7:0], 1'b0, 3'h0, 1'b0);
         if (a == IPE_LEVEL_ADDR) lvl = r[7:0] | 8'h80;
         if (a == IPE_MASK_ADDR) msk = r[7:0] & 8'hbf;
         rd_chk(a, (a == 8'h55) ? 8'h00 : (a == IPE_LEVEL_ADDR) ? lvl : msk);
         chk(level, lvl);
      end
      // Set then clear every priority bit singly
      for (int b = 0; b < 16; b++) begin
         ipe_core_model_i.put(IPE_LEVEL_ADDR, 1'b0, 8'h00, 1'b1, b[2:0], b < 8);
         lvl[b[2:0]] = (b < 8) | (b[2:0] == 3'd7);
         rd_chk(IPE_LEVEL_ADDR, lvl);
         chk(level, lvl);
      end
      ipe_core_model_i.put(IPE_MASK_ADDR, 1'b0, 8'h00, 1'b1, 3'h0, ~msk[0]);
      rd_chk(IPE_MASK_ADDR, msk);
      // Byte write and bit write together: the byte wins
      r = xs();
      ipe_core_model_i.put(IPE_LEVEL_ADDR, 1'b1, r[7:0], 1'b1, 3'h0, ~r[0]);
      lvl = r[7:0] | 8'h80;
      rd_chk(IPE_LEVEL_ADDR, lvl);
      // Reset in mid-run brings back the reset values
      srst_in = 1'b1;
      repeat (2) @(posedge clk_in);
      #1 srst_in = 1'b0;
      lvl = 8'h80;
      msk = 8'h00;
      chk(level, lvl);
      chk(rdata, 8'h00);
      rd_chk(IPE_MASK_ADDR, msk);
      rd_chk(IPE_LEVEL_ADDR, lvl);
      // Frozen clock enable keeps contents
      ce_in = 1'b0;
      ipe_core_model_i.put(IPE_LEVEL_ADDR, 1'b1, ~lvl, 1'b0, 3'h0, 1'b0);
      ce_in = 1'b1;
      rd_chk(IPE_LEVEL_ADDR, lvl);
      // Gating of the extended sources
      for (int i = 0; i < 40; i++) begin
         r = xs();
         ipe_core_model_i.put(IPE_MASK_ADDR, 1'b1, r[7:0], 1'b0, 3'h0, 1'b0);
         msk = r[7:0] & 8'hbf;
         gate = r[31] | r[30];
         flags = r[24:16];
         @(posedge clk_in);
         #1;
         chk({1'b0, req}, {1'b0, exp_req()});
      end
      report_and_stop();
   end
endmodule // tb_irq_priority_and_ext_enable
`default_nettype wire
